// ---- inc/lswc_regs.svh ----
/*
 * Register offsets, field positions, write masks and reset values of the
 * load/store watchpoint block.
 * Assumes 32-bit register words; field positions count from bit 0 = LSB.
 */
`ifndef LSWC_REGS_SVH
`define LSWC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, low address bits only)
// ----------------------------------------------------------------------
`define LSWC_DEC_W 8
`define LSWC_OFF_CMPCTL 8'h00
`define LSWC_OFF_COMBINE 8'h04
`define LSWC_OFF_CNTA 8'h08
`define LSWC_OFF_CNTB 8'h0c
`define LSWC_OFF_STEP 8'h04

// ----------------------------------------------------------------------
// Comparator control fields (upper bit of each field)
// ----------------------------------------------------------------------
`define LSWC_CT_E 31
`define LSWC_CT_F 28
`define LSWC_CT_G 25
`define LSWC_CT_H 22
`define LSWC_DIR_E 19
`define LSWC_DIR_F 17
`define LSWC_SIZE_G 15
`define LSWC_SIZE_H 13
`define LSWC_SIGN_G 11
`define LSWC_SIGN_H 10
`define LSWC_MASK_G 9
`define LSWC_MASK_H 5
`define LSWC_CMPCTL_WMASK 32'hffff_fffc
`define LSWC_CMPCTL_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Combine control fields; watchpoint 1 sits one stride below watchpoint 0
// ----------------------------------------------------------------------
`define LSWC_WP_EN 31
`define LSWC_WP_IA 30
`define LSWC_WP_IADC 28
`define LSWC_WP_LA 27
`define LSWC_WP_LADC 25
`define LSWC_WP_LD 24
`define LSWC_WP_LDDC 22
`define LSWC_WP_STRIDE 10
`define LSWC_BP_UNMASK 11
`define LSWC_PORT_EN 3
`define LSWC_SW_EN 1
`define LSWC_COMBINE_WMASK 32'hffff_f803
`define LSWC_COMBINE_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Breakpoint counter fields
// ----------------------------------------------------------------------
`define LSWC_CNT_VAL 31
`define LSWC_CNT_SRC 1
`define LSWC_CNT_RST 16'h0000
`define LSWC_CNT_ONE 16'h0001
`define LSWC_SRC_RST 2'h0

`endif

// ---- inc/lswc_pkg.sv ----
/*
 * Types and shared decoding of the load/store watchpoint block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package lswc_pkg;

	typedef enum logic [2:0] {
		LSWC_CT_OFF = 3'h0,
		LSWC_CT_EQ = 3'h4,
		LSWC_CT_LT = 3'h5,
		LSWC_CT_GT = 3'h6,
		LSWC_CT_NE = 3'h7
	} lswc_cmp_e;

	typedef enum logic [1:0] {
		LSWC_SZ_RSVD = 2'h0,
		LSWC_SZ_WORD = 2'h1,
		LSWC_SZ_HALF = 2'h2,
		LSWC_SZ_BYTE = 2'h3
	} lswc_size_e;

	typedef enum logic [1:0] {
		LSWC_SRC_OFF = 2'h0,
		LSWC_SRC_FETCH = 2'h1,
		LSWC_SRC_LS = 2'h2,
		LSWC_SRC_RSVD = 2'h3
	} lswc_src_e;

	typedef enum logic [1:0] {
		LSWC_SEL_A = 2'h0,
		LSWC_SEL_B = 2'h1,
		LSWC_SEL_AND = 2'h2,
		LSWC_SEL_OR = 2'h3
	} lswc_sel_e;

	// Patterns with a leading zero never match.
	function automatic logic lswc_compare(input logic [2:0] ct, input logic lt,
		input logic eq);
		logic r;
		r = 1'b0;
		case (ct)
			LSWC_CT_EQ: r = eq;
			LSWC_CT_LT: r = lt;
			LSWC_CT_GT: r = ~lt & ~eq;
			LSWC_CT_NE: r = ~eq;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic lswc_pick(input logic [1:0] sel, input logic a,
		input logic b);
		logic r;
		r = 1'b0;
		case (sel)
			LSWC_SEL_A: r = a;
			LSWC_SEL_B: r = b;
			LSWC_SEL_AND: r = a & b;
			default: r = a | b;
		endcase
		return r;
	endfunction

endpackage

`default_nettype wire

// ---- rtl/lswc_data_cmp.sv ----
/*
 * One data comparator: byte mask, operand size, signedness, compare type.
 * Assumes the load/store operand is right-justified in the data word.
 */
`default_nettype none

module lswc_data_cmp
	import lswc_pkg::*;
(
	input wire logic [31:0] ls_data,
	input wire logic [31:0] ref_value,
	input wire logic [2:0] cmp_type,
	input wire logic [1:0] size_sel,
	input wire logic unsgn,
	input wire logic [3:0] byte_mask,
	output logic hit
);

	logic [31:0] keep;
	logic [32:0] op_a;
	logic [32:0] op_b;
	logic lt;
	logic eq;

	// Mask bit 0 blanks the last (least significant) byte.
	genvar k;
	generate
		for (k = 0; k < 4; k++)
		begin : g_lane
			assign keep[8*k +: 8] = {8{~byte_mask[k]}};
		end
	endgenerate

	// The reserved size code is treated as a word compare.
	function automatic logic [32:0] widen(input logic [31:0] v,
		input logic [1:0] sz, input logic uns);
		logic [32:0] r;
		r = {~uns & v[31], v};
		case (sz)
			LSWC_SZ_HALF: r = {{17{~uns & v[15]}}, v[15:0]};
			LSWC_SZ_BYTE: r = {{25{~uns & v[7]}}, v[7:0]};
			default: r = {~uns & v[31], v};
		endcase
		return r;
	endfunction

	assign op_a = widen(ls_data & keep, size_sel, unsgn);
	assign op_b = widen(ref_value & keep, size_sel, unsgn);
	assign lt = $signed(op_a) < $signed(op_b);
	assign eq = op_a == op_b;
	assign hit = lswc_compare(cmp_type, lt, eq);

endmodule

`default_nettype wire

// ---- rtl/lswc_bp_counter.sv ----
/*
 * One breakpoint counter: loads its preset on a register write and counts
 * the selected watchpoint down, firing when it reaches zero.
 * Assumes event inputs are single-cycle qualifiers on sys_clk.
 */
`default_nettype none
`include "lswc_regs.svh"

module lswc_bp_counter
	import lswc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [15:0] preset,
	input wire logic [1:0] src,
	input wire logic ev_fetch,
	input wire logic ev_ls,
	output logic [15:0] count,
	output logic fire
);

	logic ev;

	assign ev = (src == LSWC_SRC_FETCH & ev_fetch) | (src == LSWC_SRC_LS & ev_ls);
	// A counter already at zero fires on every further event.
	assign fire = ev & (count <= `LSWC_CNT_ONE);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= `LSWC_CNT_RST;
		else if (load)
			count <= preset;
		else if (ev && count != `LSWC_CNT_RST)
			count <= count - `LSWC_CNT_ONE;
	end

	chk_count_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev && !load && count > `LSWC_CNT_ONE) |=> count == $past(count) - `LSWC_CNT_ONE
	) else $error("counter did not step down by one");

endmodule

`default_nettype wire

// ---- rtl/lswc_top.sv ----
/*
 * Load/store watchpoint qualification, breakpoint masking, trap routing
 * and breakpoint counters, with an AHB-Lite register slave.
 * Assumes the core's load/store, fetch-watchpoint and development-port
 * inputs come from logic on sys_clk, and comparator values come from
 * registers kept elsewhere.
 */
`default_nettype none
`include "lswc_regs.svh"

module lswc_top
	import lswc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic ls_valid,
	input wire logic ls_write,
	input wire logic [31:0] ls_addr,
	input wire logic [31:0] ls_data,
	input wire logic [31:0] addr_ref_e,
	input wire logic [31:0] addr_ref_f,
	input wire logic [31:0] data_ref_g,
	input wire logic [31:0] data_ref_h,
	input wire logic [3:0] fetch_wp,
	input wire logic recoverable_state_bit,
	input wire logic port_trap_load,
	input wire logic [1:0] port_trap_value,
	output logic [3:0] fetch_bp,
	output logic lsbp_cause_flag,
	output logic [1:0] lswp_sw_trap,
	output logic [1:0] lswp_port_trap
);

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	// Reads take one wait state so that a read right behind a write to the
	// same register already sees the new value.
	logic wr_pend;
	logic rd_pend;
	logic [`LSWC_DEC_W-1:0] acc_addr;
	logic addr_take;
	logic wr_cmp;
	logic wr_comb;
	logic [1:0] wr_cnt;
	logic [31:0] rd_mux;

	assign addr_take = hsel & hready & htrans[1];
	assign wr_cmp = wr_pend & (acc_addr == `LSWC_OFF_CMPCTL);
	assign wr_comb = wr_pend & (acc_addr == `LSWC_OFF_COMBINE);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_addr <= `LSWC_OFF_CMPCTL;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= addr_take & hwrite;
			rd_pend <= addr_take & ~hwrite;
			hreadyout <= ~(addr_take & ~hwrite);
			hresp <= 1'b0;
			if (addr_take)
				acc_addr <= haddr[`LSWC_DEC_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (rd_pend)
			hrdata <= rd_mux;
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	logic [31:0] cmp_ctl;
	logic [31:0] combine;
	logic [31:0] next_combine;
	logic [1:0] port_en;
	logic [1:0] sw_en;
	logic bp_unmasked;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cmp_ctl <= `LSWC_CMPCTL_RST;
		else if (wr_cmp)
			cmp_ctl <= hwdata & `LSWC_CMPCTL_WMASK;
	end

	// Software writes leave the development-port enables alone.
	always_comb
	begin
		next_combine = combine;
		if (wr_comb)
			next_combine = (hwdata & `LSWC_COMBINE_WMASK) |
				(combine & ~`LSWC_COMBINE_WMASK);
		if (port_trap_load)
		begin
			next_combine[`LSWC_PORT_EN] = port_trap_value[0];
			next_combine[`LSWC_PORT_EN-1] = port_trap_value[1];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			combine <= `LSWC_COMBINE_RST;
		else
			combine <= next_combine;
	end

	assign port_en = {combine[`LSWC_PORT_EN-1], combine[`LSWC_PORT_EN]};
	assign sw_en = {combine[`LSWC_SW_EN-1], combine[`LSWC_SW_EN]};
	assign bp_unmasked = combine[`LSWC_BP_UNMASK];

	// ------------------------------------------------------------------
	// Address comparators
	// ------------------------------------------------------------------
	logic hit_e;
	logic hit_f;
	logic hit_g;
	logic hit_h;

	function automatic logic dir_ok(input logic [1:0] q, input logic wr);
		return ~q[1] | (q[0] == wr);
	endfunction

	assign hit_e = lswc_compare(cmp_ctl[`LSWC_CT_E -: 3], ls_addr < addr_ref_e,
		ls_addr == addr_ref_e) & dir_ok(cmp_ctl[`LSWC_DIR_E -: 2], ls_write);
	assign hit_f = lswc_compare(cmp_ctl[`LSWC_CT_F -: 3], ls_addr < addr_ref_f,
		ls_addr == addr_ref_f) & dir_ok(cmp_ctl[`LSWC_DIR_F -: 2], ls_write);

	// ------------------------------------------------------------------
	// Data comparators
	// ------------------------------------------------------------------
	lswc_data_cmp u_cmp_g (
		.ls_data(ls_data),
		.ref_value(data_ref_g),
		.cmp_type(cmp_ctl[`LSWC_CT_G -: 3]),
		.size_sel(cmp_ctl[`LSWC_SIZE_G -: 2]),
		.unsgn(cmp_ctl[`LSWC_SIGN_G]),
		.byte_mask(cmp_ctl[`LSWC_MASK_G -: 4]),
		.hit(hit_g)
	);

	lswc_data_cmp u_cmp_h (
		.ls_data(ls_data),
		.ref_value(data_ref_h),
		.cmp_type(cmp_ctl[`LSWC_CT_H -: 3]),
		.size_sel(cmp_ctl[`LSWC_SIZE_H -: 2]),
		.unsgn(cmp_ctl[`LSWC_SIGN_H]),
		.byte_mask(cmp_ctl[`LSWC_MASK_H -: 4]),
		.hit(hit_h)
	);

	// ------------------------------------------------------------------
	// Watchpoints and counters
	// ------------------------------------------------------------------
	logic [1:0] wp_en;
	logic [1:0] cond_fetch;
	logic [1:0] cond_addr;
	logic [1:0] cond_data;
	logic [1:0] lswp_raw;
	logic [1:0] lswp_pre;
	logic [1:0] cnt_src [2];
	logic [15:0] cnt_count [2];
	logic [1:0] cnt_fire;
	logic [3:0] fetch_pre;

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_wp
			localparam int S = i * `LSWC_WP_STRIDE;
			logic [1:0] ia_sel;
			logic [15:0] cnt_off;

			assign ia_sel = combine[`LSWC_WP_IA-S -: 2];
			assign wp_en[i] = combine[`LSWC_WP_EN-S];
			assign cond_fetch[i] = ~combine[`LSWC_WP_IADC-S] | fetch_wp[ia_sel];
			assign cond_addr[i] = ~combine[`LSWC_WP_LADC-S] |
				lswc_pick(combine[`LSWC_WP_LA-S -: 2], hit_e, hit_f);
			assign cond_data[i] = ~combine[`LSWC_WP_LDDC-S] |
				lswc_pick(combine[`LSWC_WP_LD-S -: 2], hit_g, hit_h);
			assign lswp_raw[i] = ls_valid & wp_en[i] &
				cond_fetch[i] & cond_addr[i] & cond_data[i];

			assign cnt_off = 16'(`LSWC_OFF_CNTA) + 16'(i) * 16'(`LSWC_OFF_STEP);
			assign wr_cnt[i] = wr_pend & (acc_addr == cnt_off[`LSWC_DEC_W-1:0]);

			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
					cnt_src[i] <= `LSWC_SRC_RST;
				else if (wr_cnt[i])
					cnt_src[i] <= hwdata[`LSWC_CNT_SRC -: 2];
			end

			lswc_bp_counter u_cnt (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.load(wr_cnt[i]),
				.preset(hwdata[`LSWC_CNT_VAL -: 16]),
				.src(cnt_src[i]),
				.ev_fetch(fetch_wp[i]),
				.ev_ls(lswp_raw[i]),
				.count(cnt_count[i]),
				.fire(cnt_fire[i])
			);

			// A counter that owns a source replaces its raw events.
			assign lswp_pre[i] = (cnt_src[i] == LSWC_SRC_LS) ? cnt_fire[i] : lswp_raw[i];
			assign fetch_pre[i] = (cnt_src[i] == LSWC_SRC_FETCH) ? cnt_fire[i] : fetch_wp[i];
			assign fetch_pre[i+2] = fetch_wp[i+2];
		end
	endgenerate

	function automatic logic wr_cnt_hit(input int n);
		return acc_addr == (n == 0 ? `LSWC_OFF_CNTA : `LSWC_OFF_CNTB);
	endfunction

	assign rd_mux = (acc_addr == `LSWC_OFF_CMPCTL) ? cmp_ctl :
		(acc_addr == `LSWC_OFF_COMBINE) ? combine :
		wr_cnt_hit(0) ? {cnt_count[0], 14'h0000, cnt_src[0]} :
		wr_cnt_hit(1) ? {cnt_count[1], 14'h0000, cnt_src[1]} : 32'h0000_0000;

	// ------------------------------------------------------------------
	// Masking and trap routing
	// ------------------------------------------------------------------
	logic recog;
	logic [1:0] ls_bp;

	assign recog = bp_unmasked | recoverable_state_bit;
	assign ls_bp = lswp_pre & {2{recog}};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_bp <= 4'h0;
			lsbp_cause_flag <= 1'b0;
			lswp_sw_trap <= 2'h0;
			lswp_port_trap <= 2'h0;
		end
		else
		begin
			fetch_bp <= fetch_pre & {4{recog}};
			lsbp_cause_flag <= |ls_bp;
			lswp_sw_trap <= ls_bp & sw_en;
			lswp_port_trap <= ls_bp & port_en;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	chk_dir_read: assert property (
		(cmp_ctl[`LSWC_DIR_E -: 2] == 2'h2 && ls_write) |-> !hit_e
	) else $error("comparator E matched a write in read-only mode");

	chk_wp_off: assert property (
		(wp_en == 2'h0) |=> !lsbp_cause_flag && lswp_sw_trap == 2'h0
	) else $error("disabled watchpoints raised a breakpoint");

	chk_all_care_off: assert property (
		(wp_en[0] && ls_valid && combine[`LSWC_WP_IADC] == 1'b0 &&
		!combine[`LSWC_WP_LADC] && !combine[`LSWC_WP_LDDC]) |-> lswp_raw[0]
	) else $error("watchpoint with no care bits did not fire");

	chk_no_access: assert property (
		!ls_valid |=> !lsbp_cause_flag
	) else $error("load/store breakpoint without an access");

	chk_masked: assert property (
		(!bp_unmasked && !recoverable_state_bit) |=> fetch_bp == 4'h0 && !lsbp_cause_flag
	) else $error("breakpoint recognised in masked mode");

	chk_port_ro: assert property (
		!port_trap_load |=> $stable(port_en)
	) else $error("port trap enables changed without the port");

	chk_sw_route: assert property (
		(ls_bp[1] && sw_en[1]) |=> lswp_sw_trap[1] ##1 !lswp_sw_trap[1] || $past(ls_bp[1])
	) else $error("software trap not routed");

	chk_reset_val: assert property (
		$rose(rst_n) |-> combine == `LSWC_COMBINE_RST && cnt_src[0] == `LSWC_SRC_RST
	) else $error("control registers not cleared by reset");

	chk_src_off: assert property (
		(cnt_src[0] == LSWC_SRC_OFF) |-> !cnt_fire[0] && lswp_pre[0] == lswp_raw[0]
	) else $error("inactive counter A interfered");

	chk_cause: assert property (
		(|ls_bp) |=> lsbp_cause_flag
	) else $error("cause flag missed a load/store breakpoint");

	chk_read_wait: assert property (
		(addr_take && !hwrite) |=> !hreadyout ##1 hreadyout
	) else $error("read wait state wrong");

endmodule

`default_nettype wire

// ---- test/lswc_core_model.sv ----
/*
 * Core-side model: issues load/store accesses and fetch watchpoint pulses.
 * Assumes sys_clk comes from the bench, which calls the tasks below.
 */
`default_nettype none

module lswc_core_model
(
	input wire logic sys_clk,
	output logic ls_valid,
	output logic ls_write,
	output logic [31:0] ls_addr,
	output logic [31:0] ls_data,
	output logic [3:0] fetch_wp,
	output logic recoverable_state_bit
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		ls_valid = 1'b0;
		ls_write = 1'b0;
		ls_addr = 32'h0;
		ls_data = 32'h0;
		fetch_wp = 4'h0;
		recoverable_state_bit = 1'b0;
	end

	// -----------------------------------------------------------------
	// Access and state tasks
	// -----------------------------------------------------------------
	task automatic access(input logic v, input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] f);
		@(posedge sys_clk);
		ls_valid <= v;
		ls_write <= w;
		ls_addr <= a;
		ls_data <= d;
		fetch_wp <= f;
		@(posedge sys_clk);
		ls_valid <= 1'b0;
		fetch_wp <= 4'h0;
		// Idle address and data are inverted so a stale value never matches.
		ls_addr <= ~a;
		ls_data <= ~d;
	endtask

	task automatic set_ri(input logic v);
		@(posedge sys_clk);
		recoverable_state_bit <= v;
	endtask
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Self-checking bench for the load/store watchpoint block.
 * Assumes lswc_top and the core model; the bench is the bus master,
 * the development port and the source of the comparator values.
 */
`default_nettype none
`include "lswc_regs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, rst_n, hsel, hwrite, port_trap_load, hreadyout, hresp;
	logic ls_valid, ls_write, recoverable_state_bit, lsbp_cause_flag;
	logic [1:0] htrans, port_trap_value, lswp_sw_trap, lswp_port_trap;
	logic [2:0] hsize;
	logic [3:0] fetch_wp, fetch_bp;
	logic [31:0] haddr, hwdata, hrdata, ls_addr, ls_data, rdv;
	logic [31:0] addr_ref_e, addr_ref_f, data_ref_g, data_ref_h;
	logic [42:0] dcase [12];
	int miscompares, checked, i;

	lswc_core_model core (.sys_clk(sys_clk), .ls_valid(ls_valid),
		.ls_write(ls_write), .ls_addr(ls_addr), .ls_data(ls_data),
		.fetch_wp(fetch_wp), .recoverable_state_bit(recoverable_state_bit));

	lswc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.ls_valid(ls_valid), .ls_write(ls_write), .ls_addr(ls_addr),
		.ls_data(ls_data), .addr_ref_e(addr_ref_e), .addr_ref_f(addr_ref_f),
		.data_ref_g(data_ref_g), .data_ref_h(data_ref_h), .fetch_wp(fetch_wp),
		.recoverable_state_bit(recoverable_state_bit),
		.port_trap_load(port_trap_load), .port_trap_value(port_trap_value),
		.fetch_bp(fetch_bp), .lsbp_cause_flag(lsbp_cause_flag),
		.lswp_sw_trap(lswp_sw_trap), .lswp_port_trap(lswp_port_trap));

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// -----------------------------------------------------------------
	// Bus and checking tasks
	// -----------------------------------------------------------------
	task automatic results();
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			miscompares++;
			results();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready();
		rdv = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		check(nm, rdv, exp);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	// Output order: fetch_bp, cause flag, software traps, port traps.
	task automatic ls(input logic v, input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] f, input logic [8:0] exp);
		core.access(v, w, a, d, f);
		#1;
		check("ls outputs", {23'h0, fetch_bp, lsbp_cause_flag, lswp_sw_trap,
			lswp_port_trap}, {23'h0, exp});
	endtask

	function automatic logic [8:0] hx(input logic h);
		return {4'h0, h, 1'b0, h, 1'b0, h};
	endfunction

	// Watchpoint 0 fields on top; unmasked mode and its software trap set.
	function automatic logic [31:0] cw(input logic [9:0] f);
		return {f, 10'h0, 12'h802};
	endfunction

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		port_trap_load = 1'b0;
		port_trap_value = 2'h0;
		addr_ref_e = 32'h100;
		addr_ref_f = 32'h200;
		data_ref_g = 32'h12;
		data_ref_h = 32'h0;
		miscompares = 0;
		checked = 0;
		dcase = '{{3'h4, 2'h1, 1'b0, 4'h0, 32'h12, 1'b1},
			{3'h4, 2'h1, 1'b0, 4'h0, 32'h34, 1'b0},
			{3'h4, 2'h1, 1'b0, 4'h1, 32'h34, 1'b1},
			{3'h5, 2'h1, 1'b0, 4'h0, 32'hffff_ffff, 1'b1},
			{3'h5, 2'h1, 1'b1, 4'h0, 32'hffff_ffff, 1'b0},
			{3'h6, 2'h1, 1'b1, 4'h0, 32'hffff_ffff, 1'b1},
			{3'h7, 2'h1, 1'b0, 4'h0, 32'h12, 1'b0},
			{3'h7, 2'h1, 1'b0, 4'h0, 32'h13, 1'b1},
			{3'h4, 2'h3, 1'b0, 4'h0, 32'hab12, 1'b1},
			{3'h4, 2'h2, 1'b0, 4'h0, 32'h1_0012, 1'b1},
			{3'h4, 2'h2, 1'b0, 4'h0, 32'h112, 1'b0},
			{3'h3, 2'h1, 1'b0, 4'h0, 32'h12, 1'b0}};
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++)
			rd(8'(i * 4), 32'h0, "reset value");
		bus(1'b1, `LSWC_OFF_COMBINE, 32'hffff_ffff);
		rd(`LSWC_OFF_COMBINE, 32'hffff_f803, "combine");
		bus(1'b1, `LSWC_OFF_CNTA, 32'hffff_ffff);
		rd(`LSWC_OFF_CNTA, 32'hffff_0003, "counter a");
		bus(1'b1, `LSWC_OFF_CNTA, 32'h0);
		@(posedge sys_clk);
		port_trap_load <= 1'b1;
		port_trap_value <= 2'h1;
		@(posedge sys_clk);
		port_trap_load <= 1'b0;
		rd(`LSWC_OFF_COMBINE, 32'hffff_f80b, "port enable");
		bus(1'b1, `LSWC_OFF_CMPCTL, 32'h9000_0000);
		for (i = 0; i < 4; i++)
		begin
			bus(1'b1, `LSWC_OFF_COMBINE, cw({4'h8, 2'(i), 1'b1, 3'h0}));
			ls(1'b1, 1'b0, 32'h100, 32'h0, 4'h0, hx(i == 0 || i == 3));
		end
		for (i = 0; i < 8; i++)
		begin
			bus(1'b1, `LSWC_OFF_CMPCTL, 32'h9000_0000 | (32'(i / 2) << 18));
			ls(1'b1, 1'(i), 32'h100, 32'h0, 4'h0, hx(i < 4 || i % 2 == i / 2 % 2));
		end
		bus(1'b1, `LSWC_OFF_COMBINE, cw(10'h010));
		ls(1'b1, 1'b0, 32'h100, 32'h0, 4'h0, 9'h0);
		bus(1'b1, `LSWC_OFF_COMBINE, cw(10'h200));
		ls(1'b1, 1'b1, 32'h555, 32'h7, 4'h0, hx(1'b1));
		bus(1'b1, `LSWC_OFF_COMBINE, cw(10'h200) & ~32'h800);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h4, 9'h0);
		core.set_ri(1'b1);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h4, 9'h095);
		for (i = 0; i < 16; i++)
		begin
			bus(1'b1, `LSWC_OFF_COMBINE, cw({1'b1, 2'(i / 4), 1'b1, 6'h0}));
			ls(1'b1, 1'b0, 32'h555, 32'h0, 4'(1 << i % 4),
				{4'(1 << i % 4), 5'h0} | hx(i / 4 == i % 4));
		end
		bus(1'b1, `LSWC_OFF_COMBINE, cw(10'h201));
		for (i = 0; i < 12; i++)
		begin
			bus(1'b1, `LSWC_OFF_CMPCTL, {6'h0, dcase[i][42:40], 7'h0, dcase[i][39:38],
				2'h0, dcase[i][37], 1'b0, dcase[i][36:33], 6'h0});
			ls(1'b1, 1'b0, 32'h555, dcase[i][32:1], 4'h0, hx(dcase[i][0]));
		end
		bus(1'b1, `LSWC_OFF_CMPCTL, 32'h0240_5000);
		for (i = 0; i < 4; i++)
		begin
			bus(1'b1, `LSWC_OFF_COMBINE, cw({7'h40, 2'(i), 1'b1}));
			ls(1'b1, 1'b0, 32'h555, 32'h12, 4'h0, hx(i == 0 || i == 3));
		end
		// Preset 2 on a fetch source: only the second pulse may break.
		for (i = 0; i < 2; i++)
		begin
			bus(1'b1, `LSWC_OFF_CNTA + 8'(4 * i), 32'h0002_0001);
			ls(1'b0, 1'b0, 32'h0, 32'h0, 4'(1 << i), 9'h0);
			ls(1'b0, 1'b0, 32'h0, 32'h0, 4'(1 << i), {4'(1 << i), 5'h0});
		end
		bus(1'b1, `LSWC_OFF_COMBINE, cw(10'h200));
		bus(1'b1, `LSWC_OFF_CNTA, 32'h0003_0002);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, 9'h0);
		rd(`LSWC_OFF_CNTA, 32'h0002_0002, "count a");
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, 9'h0);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, hx(1'b1));
		bus(1'b1, `LSWC_OFF_CNTB, 32'h0);
		ls(1'b0, 1'b0, 32'h0, 32'h0, 4'h2, 9'h040);
		// Second watchpoint alone, no care bits, software trap enabled.
		bus(1'b1, `LSWC_OFF_COMBINE, 32'h0020_0801);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, 9'h018);
		@(posedge sys_clk);
		port_trap_load <= 1'b1;
		port_trap_value <= 2'h2;
		@(posedge sys_clk);
		port_trap_load <= 1'b0;
		bus(1'b1, `LSWC_OFF_CNTB, 32'h0002_0002);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, 9'h0);
		ls(1'b1, 1'b0, 32'h555, 32'h0, 4'h0, 9'h01a);
		results();
	end
endmodule

`default_nettype wire
